// ### core/wdog_pkg.sv
/*
  Shared constants and types for the watchdog block: register offsets,
  field layouts, reset values and timing figures.
  Assumes an 8-bit register port and a 40 MHz system clock.
*/
package wdog_pkg;

  // register offsets on the 8-bit register port
  localparam logic [7:0] CTRL_OFFSET  = 8'h21;
  localparam logic [7:0] CAUSE_OFFSET = 8'h22;

  // clock and oscillator rates
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned OSC_HZ = 128000;

  // change-enable window, in system clock cycles
  localparam logic [2:0] CE_WINDOW_CYCLES = 3'h4;

  // time-out period: base count doubled per code
  localparam int unsigned COUNT_W         = 20;
  localparam logic [20:0] PERIOD_BASE     = 21'h000800;
  localparam logic [3:0]  PRESCALE_MAX    = 4'h9;
  localparam logic [3:0]  PRESCALE_RESET  = 4'h0;

  // control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic       timeout_flag;
    logic       timeout_irq_enable;
    logic       prescale_hi;
    logic       change_enable_bit;
    logic       wdt_enable_bit;
    logic [2:0] prescale_lo;
  } ctrl_t;

  // reset-cause register layout
  typedef struct packed {
    logic [3:0] reserved;
    logic       wdog_reset_flag;
    logic       brownout_reset_flag;
    logic       external_reset_flag;
    logic       poweron_reset_flag;
  } cause_t;

  localparam ctrl_t  CTRL_RESET  = 8'h00;
  localparam cause_t CAUSE_POR   = 8'h01;

  typedef enum logic [1:0] {
    ACT_NONE  = 2'b00,
    ACT_IRQ   = 2'b01,
    ACT_RESET = 2'b10
  } action_t;

  // reserved codes fall back to the longest valid period
  function automatic logic [COUNT_W-1:0] terminal_count(input logic [3:0] sel);
    logic [3:0]  code;
    logic [20:0] period;
    code   = (sel > PRESCALE_MAX) ? PRESCALE_MAX : sel;
    period = PERIOD_BASE << code;
    return COUNT_W'(period - 21'h000001);
  endfunction

  function automatic action_t timeout_action(input logic enable, input logic irq_enable);
    if (irq_enable)
      return ACT_IRQ;
    else if (enable)
      return ACT_RESET;
    else
      return ACT_NONE;
  endfunction

endpackage

// ### core/osc_edge_sync.sv
/*
  Brings the free-running watchdog oscillator into the system clock
  domain and gives a one-cycle tick per oscillator rising edge.
  Assumes the system clock is far faster than the oscillator.
*/
`timescale 1ns/1ps
module osc_edge_sync
(
  // clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // oscillator pin and tick
  input  wire logic osc_in,
  output logic      osc_tick
);

  logic [2:0] sync_chain;
  logic       osc_level;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      sync_chain <= 3'h0;
    else
      sync_chain <= {sync_chain[1:0], osc_in};
  end

  // a change only counts once the second and third stages agree
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      osc_level <= 1'b0;
      osc_tick  <= 1'b0;
    end
    else
    begin
      osc_tick <= 1'b0;
      if (sync_chain[1] == sync_chain[2])
      begin
        osc_level <= sync_chain[2];
        osc_tick  <= sync_chain[2] & ~osc_level;
      end
    end
  end

endmodule // osc_edge_sync

// ### core/wdog_counter.sv
/*
  Watchdog count chain: counts oscillator ticks up to the selected
  period and pulses on time-out.
  Assumes ticks are one system clock cycle long.
*/
`timescale 1ns/1ps
module wdog_counter
#(
  parameter int unsigned COUNT_W = 20
)
(
  // clock and reset
  input  wire logic               clk,
  input  wire logic               reset_n,
  // control
  input  wire logic               tick,
  input  wire logic               clear,
  input  wire logic [COUNT_W-1:0] terminal,
  // status
  output logic [COUNT_W-1:0]      count,
  output logic                    timeout
);

  logic at_end;

  assign at_end = (count >= terminal);

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      count <= '0;
    else if (clear)
      count <= '0;
    else if (tick)
      count <= at_end ? '0 : count + COUNT_W'(1);
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      timeout <= 1'b0;
    else
      timeout <= tick & at_end & ~clear;
  end

endmodule // wdog_counter

// ### core/watchdog_with_reset_flags.sv
/*
  Watchdog timer with two safety levels, a timed change sequence,
  interrupt or reset on time-out, and the reset-cause register.
  Assumes reset_n is the power-on reset; other chip resets arrive as
  one-cycle pulses on the system clock; the oscillator is a pin.
*/
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
// Notes on behaviour
// - count from own 128 kHz oscillator
// - clear count on restart, disable, reset
// - ten periods; expiry with enable resets chip
// - fuse picks safety level one or two
// - level one: enable write always accepted
// - level two: enable reads one, period protected
// - change-enable clears four cycles after set
// - enable cleared only while change-enable set
// - level one: reset flag forces enable on
// - enable and irq-enable pick time-out action
// - reset-mode time-out clears irq-enable
// - time-out flag set; vector or one clears
// - interrupt needs global and local enable
// - watchdog reset flag: set, power-on/zero clears
// - brown-out, external flags behave likewise
// - power-on flag cleared only by zero write
// - upper four cause bits read zero
// - periods 2048 to 1048576 cycles, doubling
// - reserved codes act as a valid code
// - prescale split: bit five, bits two-zero
// - reset pulse lasts one system clock
module watchdog_with_reset_flags
(
  // clock and power-on reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // register port
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  output logic      [7:0] rdata,
  // oscillator pin and fuse strap
  input  wire logic       osc_128k,
  input  wire logic       safety_level_fuse,
  // cpu side
  input  wire logic       restart_pulse,
  input  wire logic       global_irq_enable,
  input  wire logic       irq_vector_ack,
  input  wire logic       external_reset_event,
  input  wire logic       brownout_reset_event,
  // outputs
  output logic            irq_request,
  output logic            wdt_reset_pulse
);

  wdog_pkg::ctrl_t            wr_ctrl;
  wdog_pkg::cause_t           wr_cause;
  wdog_pkg::cause_t           cause;
  wdog_pkg::action_t          action;
  logic                       fuse_taken;
  logic                       level2;
  logic                       change_enable_bit;
  logic [2:0]                 ce_left;
  logic                       wdt_enable_bit;
  logic                       timeout_irq_enable;
  logic                       timeout_flag;
  logic [3:0]                 prescale_select;
  logic                       enable_eff;
  logic                       running;
  logic                       ctrl_write;
  logic                       cause_write;
  logic                       sys_reset;
  logic                       osc_tick;
  logic                       timeout;
  logic [wdog_pkg::COUNT_W-1:0] count;
  logic [wdog_pkg::COUNT_W-1:0] terminal;

  assign wr_ctrl     = wdog_pkg::ctrl_t'(wdata);
  assign wr_cause    = wdog_pkg::cause_t'(wdata);
  assign ctrl_write  = wr_en && (addr == wdog_pkg::CTRL_OFFSET);
  assign cause_write = wr_en && (addr == wdog_pkg::CAUSE_OFFSET);
  // the block's own time-out reset acts on it like any chip reset
  assign sys_reset   = external_reset_event | brownout_reset_event | wdt_reset_pulse;
  assign enable_eff  = level2 | wdt_enable_bit;
  assign running     = enable_eff | timeout_irq_enable;
  assign action      = wdog_pkg::timeout_action(enable_eff, timeout_irq_enable);
  // reserved codes are folded inside the package function, so the counter
  // never sees a terminal count beyond the longest valid period
  assign terminal    = wdog_pkg::terminal_count(prescale_select);

  // oscillator ticks, crossed in from the pin
  osc_edge_sync u_osc_sync
  (
    .clk      (clk),
    .reset_n  (reset_n),
    .osc_in   (osc_128k),
    .osc_tick (osc_tick)
  );

  wdog_counter
  #(
    .COUNT_W (wdog_pkg::COUNT_W)
  )
  u_counter
  (
    .clk      (clk),
    .reset_n  (reset_n),
    .tick     (osc_tick),
    .clear    (restart_pulse | ~running | sys_reset),
    .terminal (terminal),
    .count    (count),
    .timeout  (timeout)
  );

  // fuse strap is sampled once after power-on release; level two holds
  // the enable from the cycle after that first sample, through this flop
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fuse_taken <= 1'b0;
      level2     <= 1'b0;
    end
    else if (!fuse_taken)
    begin
      fuse_taken <= 1'b1;
      level2     <= safety_level_fuse;
    end
  end

  // change-enable window
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      change_enable_bit <= 1'b0;
      ce_left           <= 3'h0;
    end
    else if (sys_reset)
    begin
      change_enable_bit <= 1'b0;
      ce_left           <= 3'h0;
    end
    else if (ctrl_write)
    begin
      change_enable_bit <= wr_ctrl.change_enable_bit & wr_ctrl.wdt_enable_bit;
      ce_left           <= wdog_pkg::CE_WINDOW_CYCLES;
    end
    else if (change_enable_bit)
    begin
      ce_left <= ce_left - 3'h1;
      if (ce_left == 3'h1)
        change_enable_bit <= 1'b0;
    end
  end

  // enable bit; level two ignores the stored value
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      wdt_enable_bit <= 1'b0;
    else if (sys_reset)
      wdt_enable_bit <= 1'b0;
    else if (cause.wdog_reset_flag && !level2)
      wdt_enable_bit <= 1'b1;
    else if (ctrl_write && wr_ctrl.wdt_enable_bit)
      wdt_enable_bit <= 1'b1;
    else if (ctrl_write && change_enable_bit)
      wdt_enable_bit <= 1'b0;
  end

  // period select; protected at level two
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      prescale_select <= wdog_pkg::PRESCALE_RESET;
    else if (sys_reset)
      prescale_select <= wdog_pkg::PRESCALE_RESET;
    else if (ctrl_write && (!level2 || change_enable_bit))
      prescale_select <= {wr_ctrl.prescale_hi, wr_ctrl.prescale_lo};
  end

  // interrupt enable; a software write in the same cycle takes priority
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      timeout_irq_enable <= 1'b0;
    else if (sys_reset)
      timeout_irq_enable <= 1'b0;
    else if (ctrl_write)
      timeout_irq_enable <= wr_ctrl.timeout_irq_enable;
    else if (timeout && enable_eff)
      timeout_irq_enable <= 1'b0;
  end

  // time-out flag: a new time-out beats a clear in the same cycle
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      timeout_flag <= 1'b0;
    else if (sys_reset)
      timeout_flag <= 1'b0;
    else if (timeout && action == wdog_pkg::ACT_IRQ)
      timeout_flag <= 1'b1;
    else if ((ctrl_write && wr_ctrl.timeout_flag) || irq_vector_ack)
      timeout_flag <= 1'b0;
  end

  // reset pulse, exactly one system clock long
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      wdt_reset_pulse <= 1'b0;
    else
      wdt_reset_pulse <= timeout && (action == wdog_pkg::ACT_RESET) && !wdt_reset_pulse;
  end

  // reset-cause flags; power-on reset is reset_n itself
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      cause <= wdog_pkg::CAUSE_POR;
    else
    begin
      cause.reserved <= 4'h0;
      if (timeout && action == wdog_pkg::ACT_RESET)
        cause.wdog_reset_flag <= 1'b1;
      else if (cause_write && !wr_cause.wdog_reset_flag)
        cause.wdog_reset_flag <= 1'b0;
      if (brownout_reset_event)
        cause.brownout_reset_flag <= 1'b1;
      else if (cause_write && !wr_cause.brownout_reset_flag)
        cause.brownout_reset_flag <= 1'b0;
      if (external_reset_event)
        cause.external_reset_flag <= 1'b1;
      else if (cause_write && !wr_cause.external_reset_flag)
        cause.external_reset_flag <= 1'b0;
      if (cause_write && !wr_cause.poweron_reset_flag)
        cause.poweron_reset_flag <= 1'b0;
    end
  end

  // interrupt request line
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      irq_request <= 1'b0;
    else
      irq_request <= timeout_flag & timeout_irq_enable & global_irq_enable;
  end

  // read port: data valid the cycle after the strobe, zero otherwise
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      rdata <= 8'h00;
    else if (rd_en && addr == wdog_pkg::CTRL_OFFSET)
      rdata <= {timeout_flag, timeout_irq_enable, prescale_select[3], change_enable_bit,
                enable_eff, prescale_select[2:0]};
    else if (rd_en && addr == wdog_pkg::CAUSE_OFFSET)
      rdata <= {4'h0, cause[3:0]};
    else
      rdata <= 8'h00;
  end

  // ---- checks ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_window_open;
    ctrl_write && wr_ctrl.change_enable_bit && wr_ctrl.wdt_enable_bit && !sys_reset;
  endsequence

  sequence s_quiet4;
    (!ctrl_write && !sys_reset) [*4];
  endsequence

  a_window_closes: assert property (s_window_open ##1 s_quiet4 |=> !change_enable_bit)
    else $error("change enable outlived its four-cycle window");

  // a write inside the window closes or restarts it, so the hold is only checked
  // across four quiet cycles
  a_window_opens: assert property (s_window_open ##1 s_quiet4 |-> change_enable_bit)
    else $error("change enable not held for four cycles");

  a_level2_enabled: assert property ((level2 && rd_en && addr == wdog_pkg::CTRL_OFFSET) |=> rdata[3])
    else $error("level two watchdog reads disabled");

  a_disable_blocked: assert property (
    (ctrl_write && !wr_ctrl.wdt_enable_bit && !change_enable_bit && wdt_enable_bit && !sys_reset)
    |=> wdt_enable_bit)
    else $error("enable cleared without change enable");

  a_flag_forces_en: assert property ((!level2 && cause.wdog_reset_flag && !sys_reset) |=> wdt_enable_bit)
    else $error("reset flag did not force enable");

  a_irq_gate: assert property (irq_request |-> $past(timeout_flag && timeout_irq_enable && global_irq_enable))
    else $error("interrupt raised without all enables");

  a_pulse_single: assert property (wdt_reset_pulse |=> !wdt_reset_pulse)
    else $error("reset pulse longer than one cycle");

  a_reset_timeout: assert property ((timeout && enable_eff && !timeout_irq_enable && !wdt_reset_pulse)
    |=> wdt_reset_pulse && cause.wdog_reset_flag ##1 (count == '0))
    else $error("reset time-out missed pulse, flag or count clear");

  a_irq_first: assert property ((timeout && enable_eff && timeout_irq_enable && !ctrl_write && !sys_reset)
    |=> !timeout_irq_enable && timeout_flag && !wdt_reset_pulse)
    else $error("combined mode time-out handled wrongly");

  a_restart_clears: assert property (restart_pulse |=> count == '0)
    else $error("restart did not clear the count");

  a_reserved_zero: assert property ((rd_en && addr == wdog_pkg::CAUSE_OFFSET) |=> rdata[7:4] == 4'h0)
    else $error("reserved cause bits read non-zero");

  a_por_survives: assert property ((external_reset_event && cause.poweron_reset_flag && !cause_write)
    |=> cause.poweron_reset_flag && cause.external_reset_flag)
    else $error("chip reset disturbed the power-on flag");

  // a chip reset wipes the control side and the count but no cause flag
  a_chip_reset_clears: assert property (sys_reset |=>
    !change_enable_bit && !timeout_irq_enable && !timeout_flag && count == '0)
    else $error("chip reset left control state behind");

  a_stopped_idle: assert property (!running |=> count == '0)
    else $error("stopped watchdog kept counting");

  a_ce_needs_enable: assert property ((ctrl_write && !wr_ctrl.wdt_enable_bit && !sys_reset)
    |=> !change_enable_bit)
    else $error("change enable opened without enable");

  a_period_locked: assert property ((level2 && ctrl_write && !change_enable_bit && !sys_reset)
    |=> $stable(prescale_select))
    else $error("level two period changed outside the window");

  a_shortest_period: assert property ((prescale_select == 4'h0) |-> (terminal == 20'h007FF))
    else $error("code zero does not end after 2048 ticks");

  a_reserved_code: assert property ((prescale_select > wdog_pkg::PRESCALE_MAX)
    |-> (terminal == {wdog_pkg::COUNT_W{1'b1}}))
    else $error("reserved code not folded onto a valid period");

  a_vector_clears: assert property ((irq_vector_ack && !(timeout && action == wdog_pkg::ACT_IRQ))
    |=> !timeout_flag)
    else $error("vector did not clear the time-out flag");

  a_brownout_sets: assert property (brownout_reset_event |=> cause.brownout_reset_flag)
    else $error("brown-out flag not set");

  a_wdog_flag_clear: assert property ((cause_write && !wr_cause.wdog_reset_flag
    && !(timeout && action == wdog_pkg::ACT_RESET)) |=> !cause.wdog_reset_flag)
    else $error("watchdog flag survived a zero write");

endmodule // watchdog_with_reset_flags

// ### bench/watchdog_with_reset_flags_tb.sv
/*
  Self-checking bench for the watchdog block: register port, timed change
  sequence, time-out actions and reset-cause flags.
  Assumes the package and design files are compiled before it.
*/
`timescale 1ns/1ps
module watchdog_with_reset_flags_tb;
  localparam logic [7:0] ctl_a = wdog_pkg::CTRL_OFFSET;
  localparam logic [7:0] cau_a = wdog_pkg::CAUSE_OFFSET;
  logic        clk;
  logic        reset_n;
  logic [7:0]  addr;
  logic [7:0]  wdata;
  logic        wr_en;
  logic        rd_en;
  logic [7:0]  rdata;
  logic        osc_128k;
  logic        safety_level_fuse;
  logic        restart_pulse;
  logic        global_irq_enable;
  logic        irq_vector_ack;
  logic        external_reset_event;
  logic        brownout_reset_event;
  logic        irq_request;
  logic        wdt_reset_pulse;
  int          n_mismatch;
  int          cmp_count;
  int          edges;
  int          osc_div;
  bit          osc_run;
  logic [31:0] seed;
  logic [7:0]  ctrl_m;

  watchdog_with_reset_flags watchdog_with_reset_flags_i
  (
    .clk                  (clk),
    .reset_n              (reset_n),
    .addr                 (addr),
    .wdata                (wdata),
    .wr_en                (wr_en),
    .rd_en                (rd_en),
    .rdata                (rdata),
    .osc_128k             (osc_128k),
    .safety_level_fuse    (safety_level_fuse),
    .restart_pulse        (restart_pulse),
    .global_irq_enable    (global_irq_enable),
    .irq_vector_ack       (irq_vector_ack),
    .external_reset_event (external_reset_event),
    .brownout_reset_event (brownout_reset_event),
    .irq_request          (irq_request),
    .wdt_reset_pulse      (wdt_reset_pulse)
  );

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // oscillator stand-in: 3 clocks per half, so the synchroniser sees every edge
  always @(posedge clk)
  begin
    if (osc_run)
    begin
      osc_div = osc_div + 1;
      if (osc_div == 3)
      begin
        osc_div = 0;
        osc_128k <= ~osc_128k;
        if (!osc_128k)
          edges = edges + 1;
      end
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic final_report();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic fail(input string msg);
    n_mismatch++;
    $display("[ERR] t=%0t %s", $time, msg);
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
      fail($sformatf("%s got %h exp %h", what, got, exp));
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    cmp_count++;
    if (got !== exp)
      fail($sformatf("%s got %b", what, got));
  endtask

  task automatic chk_range(input int got, input int lo, input int hi, input string what);
    cmp_count++;
    if (got < lo || got > hi)
      fail($sformatf("%s got %0d", what, got));
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk8(rdata, exp, what);
  endtask

  // 0 restart, 1 external reset, 2 brown-out reset, 3 vector taken
  task automatic pulse(input int which);
    @(posedge clk);
    case (which)
      0: restart_pulse <= 1'b1;
      1: external_reset_event <= 1'b1;
      2: brownout_reset_event <= 1'b1;
      default: irq_vector_ack <= 1'b1;
    endcase
    if (which == 0)
      edges = 0;
    @(posedge clk);
    restart_pulse        <= 1'b0;
    external_reset_event <= 1'b0;
    brownout_reset_event <= 1'b0;
    irq_vector_ack       <= 1'b0;
  endtask

  task automatic wait_edges(input int n);
    for (int i = 0; i < 20000 && edges < n; i++)
      @(posedge clk);
    if (edges < n)
    begin
      fail("osc wait expired");
      final_report();
    end
  endtask

  // 0 waits for the interrupt request, 1 for the reset pulse
  task automatic wait_high(input int which);
    logic s;
    s = 1'b0;
    for (int i = 0; i < 20000; i++)
    begin
      @(posedge clk);
      #1;
      s = (which == 0) ? irq_request : wdt_reset_pulse;
      if (s === 1'b1)
        break;
    end
    if (s !== 1'b1)
    begin
      fail("output wait expired");
      final_report();
    end
  endtask

  initial
  begin
    reset_n = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    osc_128k = 1'b0;
    safety_level_fuse = 1'b0;
    restart_pulse = 1'b0;
    global_irq_enable = 1'b0;
    irq_vector_ack = 1'b0;
    external_reset_event = 1'b0;
    brownout_reset_event = 1'b0;
    n_mismatch = 0;
    cmp_count = 0;
    edges = 0;
    osc_div = 0;
    osc_run = 1'b0;
    seed = 32'h8615;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(ctl_a, 8'h00, "ctrl at reset");
    rd(cau_a, 8'h01, "cause at power-on");
    rd(8'h30, 8'h00, "unmapped read");
    wr(8'h30, 8'hFF);
    wr(ctl_a, 8'h08);
    rd(ctl_a, 8'h08, "enable set");
    wr(ctl_a, 8'h00);
    rd(ctl_a, 8'h08, "unprotected clear");
    pulse(1);
    rd(cau_a, 8'h03, "external flag");
    rd(ctl_a, 8'h00, "ctrl after chip reset");
    pulse(2);
    wr(cau_a, 8'hFF);
    rd(cau_a, 8'h07, "brown-out flag, upper bits");
    wr(cau_a, 8'h00);
    rd(cau_a, 8'h00, "flags cleared");
    for (int c = 0; c < 16; c++)
    begin
      wr(ctl_a, {2'b00, c[3], 2'b00, c[2:0]});
      rd(ctl_a, {2'b00, c[3], 2'b00, c[2:0]}, "prescale code");
    end
    ctrl_m = 8'h00;
    for (int k = 0; k < 6; k++)
    begin
      seed = xs(seed);
      ctrl_m = (seed[7:0] & 8'h4F) | (ctrl_m & 8'h08);
      wr(ctl_a, seed[7:0] & 8'h4F);
      rd(ctl_a, ctrl_m, "free write");
    end
    wr(ctl_a, 8'h18);
    rd(ctl_a, 8'h18, "window open");
    repeat (4) @(posedge clk);
    rd(ctl_a, 8'h08, "window closed");
    wr(ctl_a, 8'h00);
    rd(ctl_a, 8'h08, "late second write");
    wr(ctl_a, 8'h18);
    wr(ctl_a, 8'h00);
    rd(ctl_a, 8'h00, "disabled");
    // interrupt only; a restart mid-count must push the expiry out
    @(posedge clk);
    global_irq_enable <= 1'b1;
    wr(ctl_a, 8'h40);
    pulse(0);
    osc_run = 1'b1;
    wait_edges(1000);
    pulse(0);
    wait_high(0);
    chk_range(edges, 2046, 2050, "irq period");
    osc_run = 1'b0;
    rd(ctl_a, 8'hC0, "timeout flag set");
    @(posedge clk);
    global_irq_enable <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk_bit(irq_request, 1'b0, "irq masked");
    @(posedge clk);
    global_irq_enable <= 1'b1;
    pulse(3);
    repeat (2) @(posedge clk);
    #1;
    chk_bit(irq_request, 1'b0, "irq after vector");
    rd(ctl_a, 8'h40, "flag cleared by vector");
    // both enables: interrupt first, then reset
    wr(ctl_a, 8'h48);
    pulse(0);
    osc_run = 1'b1;
    wait_edges(2060);
    rd(ctl_a, 8'h88, "irq enable dropped");
    wr(ctl_a, 8'h88);
    rd(ctl_a, 8'h08, "flag write-one clear");
    wait_high(1);
    @(posedge clk);
    #1;
    chk_bit(wdt_reset_pulse, 1'b0, "reset pulse width");
    osc_run = 1'b0;
    rd(cau_a, 8'h08, "watchdog flag");
    rd(ctl_a, 8'h08, "enable forced");
    wr(ctl_a, 8'h18);
    wr(ctl_a, 8'h00);
    rd(ctl_a, 8'h08, "disable blocked by flag");
    wr(cau_a, 8'h00);
    wr(ctl_a, 8'h18);
    wr(ctl_a, 8'h00);
    rd(ctl_a, 8'h00, "disable after flag clear");
    // safety level two after a fresh power-on
    @(posedge clk);
    reset_n <= 1'b0;
    safety_level_fuse <= 1'b1;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(ctl_a, 8'h08, "level two enabled");
    rd(cau_a, 8'h01, "power-on clears flags");
    wr(ctl_a, 8'h00);
    wr(ctl_a, 8'h03);
    rd(ctl_a, 8'h08, "period locked");
    wr(ctl_a, 8'h18);
    wr(ctl_a, 8'h03);
    rd(ctl_a, 8'h0B, "period changed");
    final_report();
  end
endmodule // watchdog_with_reset_flags_tb
